// [rtl/pss_defines.svh]
// Shared constants of the pressure sensor serial command link
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH
`define PSS_CMD_RESET     8'h1e
`define PSS_CMD_ADC_READ  8'h00
`define PSS_CONV_TOP      3'h2
`define PSS_CALIBRATION_MEMORY_TOP      4'ha
`define PSS_RATIO_MAX     3'h4
`define PSS_ADDR_TOP      6'h3b
`define PSS_CONV_BASE     16'h0040
`define PSS_CONV_LAST     16'h0001
`define PSS_CORRUPT_MASK  24'ha5a5a5
`define PSS_CAL_WORDS     8
`define PSS_WORD_W        16
`define PSS_LAST_BIT      3'h7
`define PSS_ACK_SLOT      4'h8
`define PSS_SPI_LAST      4'h7
`define PSS_TICK_LAST     4'h3
`define PSS_PIN_IDLE      4'h6
`endif

// [rtl/pss_pkg.sv]
// Types shared by both ends of the pressure sensor link
package pss_pkg;
    typedef enum logic [3:0] {
        I2C_IDLE, I2C_ADDR, I2C_ACK_PEND, I2C_ACK, I2C_WRITE,
        I2C_READ, I2C_MACK_PEND, I2C_MACK, I2C_READ_PEND
    } pss_i2c_state_t;
    typedef enum logic [1:0] {HOST_IDLE, HOST_START, HOST_BIT, HOST_STOP} pss_host_state_t;
endpackage

// [rtl/pss_link_if.sv]
// Pin-level link between the sensor end and the master end
`timescale 1ns/1ps
`default_nettype none
interface pss_link_if;
    logic sclk;
    logic select_addr_pin;
    logic ps;
    logic hostDataOut;
    logic hostDataOe;
    logic devDataOe;
    logic serial_data_out;
    logic dataLine;

    // Pulled-up shared data pin; the sensor can only pull it low
    assign dataLine = (hostDataOe ? hostDataOut : 1'b1) & ~devDataOe;

    modport dev (input sclk, input select_addr_pin, input ps, input dataLine, output devDataOe, output serial_data_out);
    modport host (output sclk, output select_addr_pin, output ps, output hostDataOut, output hostDataOe,
                  input dataLine, input serial_data_out);
endinterface
`default_nettype wire

// [rtl/pss_sensor_dev.sv]
// Sensor end: SPI/I2C command decoder, conversion timer and calibration store
// Functional notes
// - Master sends reset once after power-up
// - Conversion command starts pressure or temperature
// - Conversion continues while chip select released
// - ADC read shifts result out MSB first
// - Stale or repeated ADC read returns zero
// - Read during conversion gives zero, corrupts result
// - Master avoids conversion command while converting
// - Calibration memory holds eight 16-bit words
// - Calibration read answers 16 bits MSB first
// - Master reads calibration once after reset
// - I2C transactions framed by START and STOP
// - I2C address 111011 then inverted select
// - I2C reset command accepted at any time
// - Master recovers stuck data line with clocks
// - I2C calibration read: write command, then read
// - I2C conversion busy until finished
// - I2C result read: 24 bits, ack each byte but the last
// - Calibration memory carries a 4-bit CRC
// - Differential parts read mid-scale at equal pressure
// - One-byte command codes
// - Select pin low SPI, high I2C
// - SPI mode 0 and mode 3 supported
// - ADC read 24 bits, calibration read 16
`timescale 1ns/1ps
`default_nettype none
`include "pss_defines.svh"
module pss_sensor_dev (
    input  wire logic         clk,
    input  wire logic         reset,
    pss_link_if.dev           link,
    input  wire logic [127:0] calibImage,
    input  wire logic [23:0]  rawPressureSample,
    input  wire logic [23:0]  rawTemperatureSample,
    output logic              convBusy,
    output logic              resultReady
);
    // ************************************************************
    // Pin synchronisers and edge detection
    // ************************************************************
    logic [3:0] syncAQ;
    logic [3:0] syncBQ;
    logic [3:0] prevQ;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            // Idle pin levels, so no false edge or select follows reset
            syncAQ <= `PSS_PIN_IDLE;
            syncBQ <= `PSS_PIN_IDLE;
            prevQ  <= `PSS_PIN_IDLE;
        end else begin
            syncAQ <= {link.ps, link.select_addr_pin, link.dataLine, link.sclk};
            syncBQ <= syncAQ;
            prevQ  <= syncBQ;
        end
    end

    wire sclS     = syncBQ[0];
    wire dataS    = syncBQ[1];
    wire csbS     = syncBQ[2];
    wire i2cMode  = syncBQ[3];
    wire spiSel   = ~i2cMode & ~csbS;
    // sample on rise, drive on fall, so both idle levels work
    wire clkRise  = sclS & ~prevQ[0];
    wire clkFall  = ~sclS & prevQ[0];
    // START and STOP frame every I2C transaction
    wire startCond = i2cMode & sclS & prevQ[0] & ~dataS & prevQ[1];
    wire stopCond  = i2cMode & sclS & prevQ[0] & dataS & ~prevQ[1];

    // ************************************************************
    // Command byte reception and decode
    // ************************************************************
    pss_pkg::pss_i2c_state_t stateQ;
    logic [6:0] rxQ;
    logic [2:0] bitCntQ;
    logic       spiDataQ;
    logic       rwQ;

    wire inAddr    = stateQ == pss_pkg::I2C_ADDR;
    wire inWrite   = stateQ == pss_pkg::I2C_WRITE;
    wire inRead    = stateQ == pss_pkg::I2C_READ;
    wire bitIn     = clkRise & ((spiSel & ~spiDataQ) | (i2cMode & (inAddr | inWrite)));
    wire [7:0] rxByte = {rxQ, dataS};
    wire byteDone  = bitIn & (bitCntQ == `PSS_LAST_BIT);
    wire execCmd   = byteDone & (~i2cMode | inWrite);
    // address match with inverted select pin
    wire addrHit   = rxByte[7:1] == {`PSS_ADDR_TOP, ~csbS};
    wire isReset   = rxByte == `PSS_CMD_RESET;
    wire isAdcRead = rxByte == `PSS_CMD_ADC_READ;
    wire isConv    = (rxByte[7:5] == `PSS_CONV_TOP) & ~rxByte[0] & (rxByte[3:1] <= `PSS_RATIO_MAX);
    wire isProm    = (rxByte[7:4] == `PSS_CALIBRATION_MEMORY_TOP) & ~rxByte[0];
    // reset acts whatever the device is doing
    wire doReset   = execCmd & isReset;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rxQ     <= 7'h00;
            bitCntQ <= 3'h0;
            spiDataQ <= 1'b0;
        end else begin
            if (bitIn)
                rxQ <= rxByte[6:0];
            // chip select release reframes the command
            if ((~i2cMode & csbS) | startCond)
                bitCntQ <= 3'h0;
            else if (bitIn | (i2cMode & clkRise & inRead))
                bitCntQ <= bitCntQ + 3'h1;
            if (i2cMode | csbS)
                spiDataQ <= 1'b0;
            else if (byteDone)
                spiDataQ <= 1'b1;
        end
    end

    // ************************************************************
    // Conversion timer and result holding
    // ************************************************************
    logic        busyQ;
    logic        validQ;
    logic        corruptQ;
    logic        typeQ;
    logic [15:0] cntQ;
    logic [23:0] resultQ;

    wire convDone = busyQ & (cntQ == `PSS_CONV_LAST);
    wire [23:0] sample = typeQ ? rawTemperatureSample : rawPressureSample;
    // zero unless a fresh, finished result waits
    wire [23:0] adcReply = (validQ & ~busyQ) ? resultQ : 24'h000000;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busyQ    <= 1'b0;
            validQ   <= 1'b0;
            corruptQ <= 1'b0;
            typeQ    <= 1'b0;
            cntQ     <= 16'h0000;
            resultQ  <= 24'h000000;
        end else if (doReset) begin
            busyQ    <= 1'b0;
            validQ   <= 1'b0;
            corruptQ <= 1'b0;
            resultQ  <= 24'h000000;
        end else begin
            // raw sample passes unscaled, mid-scale stays mid-scale
            if (convDone) begin
                busyQ   <= 1'b0;
                validQ  <= 1'b1;
                resultQ <= sample ^ (corruptQ ? `PSS_CORRUPT_MASK : 24'h000000);
            end else if (busyQ) begin
                cntQ <= cntQ - 16'h0001;
            end
            // a second start only spoils the running one
            if (execCmd & isConv) begin
                if (busyQ) begin
                    corruptQ <= 1'b1;
                end else begin
                    busyQ    <= 1'b1;
                    cntQ     <= `PSS_CONV_BASE << rxByte[3:1];
                    typeQ    <= rxByte[4];
                    corruptQ <= 1'b0;
                end
            end
            // early read keeps converting but spoils the value
            if (execCmd & isAdcRead) begin
                if (~convDone)
                    validQ <= 1'b0;
                if (busyQ)
                    corruptQ <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Calibration memory
    // ************************************************************
    // eight words, word 7 ends in the CRC
    // CRC nibble is stored in word 7 low bits
    logic [15:0] calMemQ [0:`PSS_CAL_WORDS-1];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < `PSS_CAL_WORDS; i++)
                calMemQ[i] <= 16'h0000;
        end else if (doReset) begin
            // reset loads the image into working storage
            for (int i = 0; i < `PSS_CAL_WORDS; i++)
                calMemQ[i] <= calibImage[i*`PSS_WORD_W +: `PSS_WORD_W];
        end
    end

    // ************************************************************
    // Reply shifter and SPI output
    // ************************************************************
    logic [23:0] txQ;
    logic        sdoQ;
    logic        devOeQ;

    wire i2cShift = i2cMode & clkFall & ((stateQ == pss_pkg::I2C_ACK & rwQ) | inRead |
                                         stateQ == pss_pkg::I2C_READ_PEND);
    wire spiShift = spiSel & clkFall & spiDataQ;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            txQ  <= 24'h000000;
            sdoQ <= 1'b0;
        end else begin
            // 24-bit result or 16-bit word, left aligned
            // calibration word goes out MSB first
            if (execCmd & isAdcRead)
                txQ <= adcReply;
            else if (execCmd & isProm)
                txQ <= {calMemQ[rxByte[3:1]], 8'h00};
            // MSB first on each falling edge
            else if (spiShift | i2cShift)
                txQ <= {txQ[22:0], 1'b0};
            if (~spiSel)
                sdoQ <= 1'b0;
            else if (spiShift)
                sdoQ <= txQ[23];
        end
    end

    // ************************************************************
    // I2C byte sequencing
    // ************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stateQ <= pss_pkg::I2C_IDLE;
            rwQ    <= 1'b0;
        end else if (~i2cMode | stopCond) begin
            stateQ <= pss_pkg::I2C_IDLE;
        end else if (startCond) begin
            stateQ <= pss_pkg::I2C_ADDR;
        end else begin
            case (stateQ)
                pss_pkg::I2C_ADDR: begin
                    if (byteDone) begin
                        stateQ <= addrHit ? pss_pkg::I2C_ACK_PEND : pss_pkg::I2C_IDLE;
                        rwQ    <= rxByte[0];
                    end
                end
                pss_pkg::I2C_ACK_PEND: if (clkFall) stateQ <= pss_pkg::I2C_ACK;
                // read transaction replays the last command's data
                pss_pkg::I2C_ACK: begin
                    if (clkFall)
                        stateQ <= rwQ ? pss_pkg::I2C_READ : pss_pkg::I2C_WRITE;
                end
                pss_pkg::I2C_WRITE: if (byteDone) stateQ <= pss_pkg::I2C_ACK_PEND;
                // stop after 8 bits for the master's acknowledge
                pss_pkg::I2C_READ: begin
                    if (clkRise & (bitCntQ == `PSS_LAST_BIT))
                        stateQ <= pss_pkg::I2C_MACK_PEND;
                end
                pss_pkg::I2C_MACK_PEND: if (clkFall) stateQ <= pss_pkg::I2C_MACK;
                pss_pkg::I2C_MACK: begin
                    if (clkRise)
                        stateQ <= dataS ? pss_pkg::I2C_IDLE : pss_pkg::I2C_READ_PEND;
                end
                pss_pkg::I2C_READ_PEND: if (clkFall) stateQ <= pss_pkg::I2C_READ;
                default: stateQ <= pss_pkg::I2C_IDLE;
            endcase
        end
    end

    // Data pin is only ever pulled low: ack slot or a zero data bit
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            devOeQ <= 1'b0;
        else if (~i2cMode | startCond | stopCond)
            devOeQ <= 1'b0;
        else if (clkFall)
            devOeQ <= i2cShift ? ~txQ[23] : (stateQ == pss_pkg::I2C_ACK_PEND);
    end

    // busy visible until the conversion count ends; resultReady stays until the result is taken over
    assign convBusy       = busyQ;
    assign resultReady    = validQ;
    assign link.serial_data_out       = sdoQ;
    assign link.devDataOe = devOeQ;
endmodule
`default_nettype wire

// [rtl/pss_master_host.sv]
// Master end: issues one-byte commands over SPI mode 0 or I2C
`timescale 1ns/1ps
`default_nettype none
`include "pss_defines.svh"
module pss_master_host (
    input  wire logic        clk,
    input  wire logic        reset,
    pss_link_if.host         link,
    input  wire logic        useI2c,
    input  wire logic        addrSelectHigh,
    input  wire logic        reqValid,
    input  wire logic [7:0]  reqCmd,
    input  wire logic [1:0]  reqReadBytes,
    input  wire logic        reqRecover,
    output logic             reqReady,
    output logic             rspValid,
    output logic [23:0]      rspData
);
    pss_pkg::pss_host_state_t stateQ;
    logic [3:0]  divQ;
    logic [1:0]  phaseQ;
    logic [3:0]  bitQ;
    logic [1:0]  byteIdxQ;
    logic [1:0]  lastByteQ;
    logic [1:0]  lenQ;
    logic [7:0]  cmdQ;
    logic [7:0]  shQ;
    logic [23:0] rxQ;
    logic        txnReadQ;
    logic        recoverQ;
    logic        initPendQ;
    logic        sclQ;
    logic        csbQ;
    logic        psQ;
    logic        outQ;
    logic        oeQ;
    logic        readyQ;
    logic        rspValidQ;
    logic [23:0] rspDataQ;
    logic [1:0]  syncAQ;
    logic [1:0]  syncBQ;

    // ************************************************************
    // Decode of the current bit slot
    // ************************************************************
    wire tick      = divQ == `PSS_TICK_LAST;
    wire inBit     = psQ ? syncBQ[0] : syncBQ[1];
    wire writeByte = (byteIdxQ == 2'h0) | (psQ & ~txnReadQ);
    wire lastByte  = byteIdxQ == lastByteQ;
    wire lastBit   = bitQ == (psQ ? `PSS_ACK_SLOT : `PSS_SPI_LAST);
    wire ackSlot   = psQ & (bitQ == `PSS_ACK_SLOT);
    // acknowledge every read byte except the last
    wire pullLow   = ackSlot ? (~writeByte & ~lastByte) : (writeByte & ~shQ[7]);
    wire [7:0] addrByte = {`PSS_ADDR_TOP, ~csbQ, txnReadQ};
    wire takeReq   = (stateQ == pss_pkg::HOST_IDLE) & (initPendQ | (reqValid & readyQ));
    // recovery is nine free clocks, STOP, then reset
    wire doRecover = ~initPendQ & reqRecover & psQ;
    wire forceRst  = initPendQ | doRecover;
    wire [7:0] startCmd = forceRst ? `PSS_CMD_RESET : reqCmd;
    wire [1:0] startLen = forceRst ? 2'h0 : reqReadBytes;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            divQ   <= 4'h0;
            syncAQ <= 2'h0;
            syncBQ <= 2'h0;
        end else begin
            divQ   <= tick ? 4'h0 : divQ + 4'h1;
            syncAQ <= {link.serial_data_out, link.dataLine};
            syncBQ <= syncAQ;
        end
    end

    // ************************************************************
    // Transaction sequencer
    // ************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stateQ <= pss_pkg::HOST_IDLE;
            {phaseQ, bitQ, byteIdxQ, lastByteQ, lenQ} <= 12'h000;
            {cmdQ, shQ} <= 16'h0000;
            rxQ <= 24'h000000;
            rspDataQ <= 24'h000000;
            {txnReadQ, recoverQ, sclQ, psQ, outQ, oeQ, readyQ, rspValidQ} <= 8'h00;
            csbQ <= 1'b1;
            // first job after power-up is the reset command
            initPendQ <= 1'b1;
        end else begin
            rspValidQ <= 1'b0;
            psQ <= useI2c;
            if (tick)
                phaseQ <= phaseQ + 2'h1;
            case (stateQ)
                pss_pkg::HOST_IDLE: begin
                    readyQ <= ~initPendQ & ~takeReq;
                    csbQ   <= psQ ? addrSelectHigh : 1'b1;
                    phaseQ <= 2'h0;
                    if (takeReq) begin
                        initPendQ <= 1'b0;
                        cmdQ      <= startCmd;
                        lenQ      <= startLen;
                        rxQ       <= 24'h000000;
                        bitQ      <= 4'h0;
                        recoverQ  <= doRecover;
                        txnReadQ  <= doRecover;
                        if (doRecover) begin
                            byteIdxQ  <= 2'h1;
                            lastByteQ <= 2'h1;
                            oeQ       <= 1'b0;
                            stateQ    <= pss_pkg::HOST_BIT;
                        end else if (psQ) begin
                            stateQ <= pss_pkg::HOST_START;
                        end else begin
                            csbQ      <= 1'b0;
                            shQ       <= startCmd;
                            byteIdxQ  <= 2'h0;
                            lastByteQ <= startLen;
                            oeQ       <= 1'b1;
                            outQ      <= 1'b0;
                            stateQ    <= pss_pkg::HOST_BIT;
                        end
                    end
                end
                pss_pkg::HOST_START: if (tick) begin
                    case (phaseQ)
                        2'h0: {oeQ, sclQ} <= 2'b01;
                        2'h1: {oeQ, outQ} <= 2'b10;
                        2'h2: begin
                            sclQ      <= 1'b0;
                            shQ       <= addrByte;
                            bitQ      <= 4'h0;
                            byteIdxQ  <= 2'h0;
                            lastByteQ <= txnReadQ ? lenQ : 2'h1;
                            phaseQ    <= 2'h0;
                            stateQ    <= pss_pkg::HOST_BIT;
                        end
                        default: phaseQ <= 2'h0;
                    endcase
                end
                pss_pkg::HOST_BIT: if (tick) begin
                    case (phaseQ)
                        2'h0: sclQ <= 1'b0;
                        2'h1: begin
                            oeQ  <= psQ ? pullLow : 1'b1;
                            outQ <= ~psQ & writeByte & shQ[7];
                        end
                        2'h2: sclQ <= 1'b1;
                        default: begin
                            if (~writeByte & ~ackSlot)
                                rxQ <= {rxQ[22:0], inBit};
                            if (~ackSlot)
                                shQ <= {shQ[6:0], 1'b0};
                            if (~lastBit) begin
                                bitQ <= bitQ + 4'h1;
                            end else begin
                                bitQ <= 4'h0;
                                if (lastByte) begin
                                    stateQ <= pss_pkg::HOST_STOP;
                                end else begin
                                    byteIdxQ <= byteIdxQ + 2'h1;
                                    shQ      <= cmdQ;
                                end
                            end
                        end
                    endcase
                end
                pss_pkg::HOST_STOP: if (tick) begin
                    // chip select dropped while the sensor converts
                    if (~psQ) begin
                        // Mode 0 clock idles low between frames
                        sclQ      <= 1'b0;
                        csbQ      <= 1'b1;
                        rspValidQ <= 1'b1;
                        rspDataQ  <= rxQ;
                        stateQ    <= pss_pkg::HOST_IDLE;
                    end else begin
                        case (phaseQ)
                            2'h0: sclQ <= 1'b0;
                            2'h1: {oeQ, outQ} <= 2'b10;
                            2'h2: sclQ <= 1'b1;
                            default: begin
                                oeQ <= 1'b0;
                                // command write first, data read second
                                if (recoverQ) begin
                                    recoverQ <= 1'b0;
                                    txnReadQ <= 1'b0;
                                    stateQ   <= pss_pkg::HOST_START;
                                end else if (~txnReadQ & (lenQ != 2'h0)) begin
                                    txnReadQ <= 1'b1;
                                    stateQ   <= pss_pkg::HOST_START;
                                end else begin
                                    rspValidQ <= 1'b1;
                                    rspDataQ  <= rxQ;
                                    stateQ    <= pss_pkg::HOST_IDLE;
                                end
                            end
                        endcase
                    end
                end
                default: stateQ <= pss_pkg::HOST_IDLE;
            endcase
        end
    end

    assign link.sclk        = sclQ;
    assign link.select_addr_pin         = csbQ;
    assign link.ps          = psQ;
    assign link.hostDataOut = outQ;
    assign link.hostDataOe  = oeQ;
    assign reqReady         = readyQ;
    assign rspValid         = rspValidQ;
    assign rspData          = rspDataQ;
endmodule
`default_nettype wire

// [sim/pss_link_assertions.sv]
// Pin-level assertions on the link between both ends
`timescale 1ns/1ps
`default_nettype none
module pss_link_assertions (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic select_addr_pin,
    input wire logic ps,
    input wire logic hostDataOut,
    input wire logic hostDataOe,
    input wire logic devDataOe,
    input wire logic serial_data_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence spiIdle; !ps && select_addr_pin; endsequence
    a_sdo_idle_low: assert property (spiIdle [*6] |-> !serial_data_out)
        else $error("sdo active while deselected");
    a_spi_no_pull: assert property (!ps |-> !devDataOe)
        else $error("sensor pulls data pin in spi");
    a_sclk_idle_low: assert property (spiIdle |-> !sclk)
        else $error("sclk high while deselected");
    a_spi_data_driven: assert property (!ps && !select_addr_pin && sclk |-> hostDataOe)
        else $error("data pin undriven at sample");
    a_bit_stable_high: assert property (!ps && sclk |-> $stable(hostDataOut))
        else $error("data moved while sclk high");
    a_sclk_high_span: assert property (!ps && $rose(sclk) |-> sclk [*4] ##[1:12] !sclk)
        else $error("sclk high phase wrong");
    a_i2c_drive_hold: assert property (ps && sclk && $past(sclk) |-> $stable(devDataOe))
        else $error("sensor moved data while scl high");
    a_i2c_low_drive: assert property (ps && $rose(devDataOe) |-> !sclk)
        else $error("sensor pulled data with scl high");
endmodule
`default_nettype wire

// [sim/tb_pressure_sensor_serial_command_if.sv]
// Self-checking bench joining the sensor end and the master end
`timescale 1ns/1ps
`default_nettype none
module tb_pressure_sensor_serial_command_if;
    logic         clk = 0, reset = 1, useI2c = 0, addrSel = 0, reqValid = 0;
    logic [7:0]   reqCmd = 8'h00;
    logic [1:0]   reqReadBytes = 2'h0;
    logic [127:0] calib = '0;
    logic [23:0]  press = '0, temp = '0, rspData, res = '0;
    logic         reqReady, rspValid, convBusy, resultReady, recover = 0;
    int           miscompares = 0, comparisons = 0;
    bit           ready = 0;

    always #20 clk = ~clk;
    pss_link_if link ();
    pss_sensor_dev u_pss_sensor_dev (.clk(clk), .reset(reset), .link(link.dev),
        .calibImage(calib), .rawPressureSample(press), .rawTemperatureSample(temp),
        .convBusy(convBusy), .resultReady(resultReady));
    pss_master_host u_pss_master_host (.clk(clk), .reset(reset), .link(link.host),
        .useI2c(useI2c), .addrSelectHigh(addrSel), .reqValid(reqValid), .reqCmd(reqCmd),
        .reqReadBytes(reqReadBytes), .reqRecover(recover), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData));
    pss_link_assertions u_chk (.clk(clk), .reset(reset), .sclk(link.sclk), .select_addr_pin(link.select_addr_pin),
        .ps(link.ps), .hostDataOut(link.hostDataOut), .hostDataOe(link.hostDataOe),
        .devDataOe(link.devDataOe), .serial_data_out(link.serial_data_out));

    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t rspData %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_status(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t busy ready %h expected %h", $time, got, exp);
        end
    endtask

    // ****************************************
    // Reference model and one host request
    // ****************************************
    task automatic xfer(input logic [7:0] c, input logic [1:0] n, input bit early = 0);
        logic [23:0] e;
        e = 24'h000000;
        if (c == 8'h1e) ready = 0;
        else if (c[7:4] == 4'ha) e = {8'h00, calib[16*c[3:1] +: 16]};
        else if (c[6]) begin
            res = c[4] ? temp : press;
            ready = 1;
        end
        else if (early) res = res ^ 24'ha5a5a5;
        else begin
            e = ready ? res : 24'h000000;
            ready = 0;
        end
        @(negedge clk);
        reqCmd = c;
        reqReadBytes = n;
        reqValid = 1;
        repeat (3000) if (reqReady !== 1'b1) @(negedge clk);
        if (reqReady !== 1'b1) miscompares++;
        @(negedge clk);
        reqValid = 0;
        repeat (3000) if (rspValid !== 1'b1) @(posedge clk) #1;
        if (rspValid !== 1'b1) miscompares++;
        if (n != 0) chk(rspData, e);
    endtask

    initial begin
        #4000000;
        miscompares++;
        complete_run();
    end

    initial begin
        void'($urandom(99));
        calib = {$urandom, $urandom, $urandom, $urandom};
        press = 24'($urandom);
        temp = 24'($urandom);
        repeat (20) @(posedge clk);
        @(negedge clk) reset = 0;
        for (int m = 0; m < 2; m++) begin
            @(negedge clk);
            useI2c = m[0];
            addrSel = 1'($urandom);
            xfer(8'h1e, 2'h0);
            for (int w = 0; w < 8; w++) xfer(8'ha0 | 8'(w << 1), 2'h2);
            for (int k = 0; k < 10; k++) begin
                xfer(8'h40 + 8'(k / 5 * 16 + k % 5 * 2), 2'h0);
                chk_status({convBusy, resultReady}, 2'h2);
                repeat ((64 << (k % 5)) + 40) @(posedge clk);
                @(negedge clk);
                chk_status({convBusy, resultReady}, 2'h1);
                xfer(8'h00, 2'h3);
                xfer(8'h00, 2'h3);
            end
            xfer(8'h48, 2'h0);
            xfer(8'h00, 2'h3, 1);
            repeat (1100) @(posedge clk);
            xfer(8'h00, 2'h3);
            xfer(8'h58, 2'h0);
            recover = m[0];
            xfer(8'h1e, 2'h0);
            recover = 1'b0;
            xfer(8'h00, 2'h3);
            $display("mode %0d test done", m);
        end
        complete_run();
    end
endmodule
`default_nettype wire
